/* cpm_consts.vh */
// Constants of the core register set
`ifndef CPM_CONSTS_VH
`define CPM_CONSTS_VH
`define CPM_SIZE_BYTE 2'h0
`define CPM_SIZE_WORD 2'h1
`define CPM_SIZE_LONG 2'h2
`define CPM_SR_C 0
`define CPM_SR_V 1
`define CPM_SR_Z 2
`define CPM_SR_N 3
`define CPM_SR_X 4
`define CPM_SR_IPL_LO 8
`define CPM_SR_IPL_HI 10
`define CPM_SR_S 13
`define CPM_SR_T 15
`define CPM_SR_RESET 16'h2700
`define CPM_SR_WMASK 16'ha71f
`define CPM_SP_RESET 32'h00000000
`define CPM_PC_RESET 32'h00000000
`define CPM_MODE_DN 4'h0
`define CPM_MODE_AN 4'h1
`define CPM_MODE_IND 4'h2
`define CPM_MODE_POSTINC 4'h3
`define CPM_MODE_PREDEC 4'h4
`define CPM_MODE_D16 4'h5
`define CPM_MODE_D8X 4'h6
`define CPM_MODE_ABSW 4'h7
`define CPM_MODE_ABSL 4'h8
`define CPM_MODE_PCD16 4'h9
`define CPM_MODE_PCD8X 4'ha
`define CPM_MODE_IMM 4'hb
`define CPM_MODE_QUICK 4'hc
`define CPM_MODE_IMPLIED 4'hd
`define CPM_MODE_COUNT 14
`define CPM_TYPE_BIT 3'h0
`define CPM_TYPE_BCD 3'h1
`define CPM_TYPE_BYTE 3'h2
`define CPM_TYPE_WORD 3'h3
`define CPM_TYPE_LONG 3'h4
`endif

/* cpm_core_regs.v */
// Architectural register set of the core: data, address, stacks, counter, status
// How it works
// RQ1: Every data, address and stack register and the program counter is a full 32-bit value; status is 16 bits.
// RQ2: Eight data registers written at byte, word or long-word width.
// RQ3: Data register operations update condition flags from the result.
// RQ4: Address registers and user stack take word or long only, flags untouched.
// RQ5: Any data or address register can be read as index register.
// RQ6: Status upper byte and supervisor stack written only in supervisor mode.
// RQ7: Status holds three-bit interrupt mask plus X, N, Z, V, C flags.
// RQ8: Status holds trace flag and supervisor/user flag.
// RQ9: Fourteen addressing modes and five data types are recognised.
// RQ10: Quick immediate encodes values one to eight, apart from full immediate.
// RQ11: Addresses are 32 bits, data moves over a 16-bit path.
// RQ12: User-mode write to status upper byte is dropped and flags a violation.
module cpm_core_regs (
    input wire clock,
    input wire resetn,
    input wire d_we,
    input wire [2:0] d_sel,
    input wire [1:0] d_size,
    input wire [31:0] d_wdata,
    input wire d_flags_en,
    input wire d_flag_v,
    input wire d_flag_c,
    input wire d_flag_x,
    input wire a_we,
    input wire [2:0] a_sel,
    input wire [1:0] a_size,
    input wire [31:0] a_wdata,
    input wire sr_we,
    input wire sr_upper_we,
    input wire [15:0] sr_wdata,
    input wire ssp_we,
    input wire [31:0] ssp_wdata,
    input wire pc_we,
    input wire [31:0] pc_wdata,
    input wire pc_inc,
    input wire [3:0] idx_sel,
    input wire idx_long,
    input wire [3:0] ea_mode,
    input wire [2:0] ea_type,
    input wire [2:0] quick_code,
    input wire [2:0] rd_sel,
    output reg [31:0] d_rdata,
    output reg [31:0] a_rdata,
    output reg [31:0] idx_value,
    output reg [31:0] program_counter,
    output reg [31:0] address_out,
    output reg [15:0] status_register,
    output reg [31:0] user_stack_pointer,
    output reg [31:0] supervisor_stack_pointer,
    output reg [31:0] quick_value,
    output reg ea_valid,
    output reg type_valid,
    output reg privilege_violation
);
`include "cpm_consts.vh"
    wire [31:0] data_register_set [0:7];
    wire [31:0] address_register_set [0:6];
    wire supervisor = status_register[`CPM_SR_S];
    // Width-qualified address writes: bytes are promoted to words
    wire [1:0] a_size_ok = (a_size == `CPM_SIZE_BYTE) ? `CPM_SIZE_WORD : a_size; // RQ4
    wire [31:0] a_wdata_ext = (a_size_ok == `CPM_SIZE_WORD) ?
        {{16{a_wdata[15]}}, a_wdata[15:0]} : a_wdata;
    wire a_is_usp = (a_sel == 3'h7);
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_data
            cpm_reg32 #(.WIDTH(32)) u_d (
                .clock(clock),
                .resetn(resetn),
                .we(d_we && (d_sel == gi)),
                .size(d_size), // RQ2
                .wdata(d_wdata),
                .q(data_register_set[gi])
            );
        end
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_addr
            cpm_reg32 #(.WIDTH(32)) u_a (
                .clock(clock),
                .resetn(resetn),
                .we(a_we && (a_sel == gi)),
                .size(`CPM_SIZE_LONG), // RQ4
                .wdata(a_wdata_ext),
                .q(address_register_set[gi])
            );
        end
    endgenerate
    // Result of the data write in progress, taken from d_wdata at d_size, not registered
    reg [31:0] res;
    reg res_n;
    reg res_z;
    always @* begin
        res = d_wdata;
        res_n = 1'b0;
        res_z = 1'b0;
        case (d_size)
            `CPM_SIZE_BYTE: begin
                res_n = res[7];
                res_z = (res[7:0] == 8'h00);
            end
            `CPM_SIZE_WORD: begin
                res_n = res[15];
                res_z = (res[15:0] == 16'h0000);
            end
            default: begin
                res_n = res[31];
                res_z = (res == 32'h00000000);
            end
        endcase
    end
    // Status register update
    wire [15:0] sr_wmasked = sr_wdata & `CPM_SR_WMASK;
    reg [15:0] next_sr;
    reg next_viol;
    always @* begin
        next_sr = status_register;
        next_viol = 1'b0;
        if (sr_we) begin
            if (sr_upper_we && supervisor) begin
                next_sr = sr_wmasked; // RQ6 RQ7 RQ8
            end else begin
                next_sr[7:0] = sr_wmasked[7:0];
                next_viol = sr_upper_we; // RQ12
            end
        end else if (d_we && d_flags_en) begin
            next_sr[`CPM_SR_N] = res_n; // RQ3
            next_sr[`CPM_SR_Z] = res_z;
            next_sr[`CPM_SR_V] = d_flag_v;
            next_sr[`CPM_SR_C] = d_flag_c;
            next_sr[`CPM_SR_X] = d_flag_x;
        end
    end
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_register <= `CPM_SR_RESET;
            privilege_violation <= 1'b0;
            user_stack_pointer <= `CPM_SP_RESET;
            supervisor_stack_pointer <= `CPM_SP_RESET;
            program_counter <= `CPM_PC_RESET;
            address_out <= `CPM_PC_RESET;
        end else begin
            status_register <= next_sr;
            privilege_violation <= next_viol || (ssp_we && !supervisor); // RQ12
            if (a_we && a_is_usp) begin
                user_stack_pointer <= a_wdata_ext; // RQ4
            end
            if (ssp_we && supervisor) begin
                supervisor_stack_pointer <= ssp_wdata; // RQ6
            end
            if (pc_we) begin
                program_counter <= pc_wdata; // RQ1
            end else if (pc_inc) begin
                program_counter <= program_counter + 32'h00000002; // RQ11
            end
            address_out <= pc_we ? pc_wdata : program_counter; // RQ11
        end
    end
    // Register reads, index select, mode and type checks
    // Slot seven of the address bank reads as whichever stack pointer is active; writes to it load the user stack pointer
    wire [31:0] active_sp = supervisor ? supervisor_stack_pointer : user_stack_pointer;
    reg [31:0] a_read;
    reg [31:0] x_addr;
    reg [31:0] idx_raw;
    reg [3:0] q_val;
    always @* begin
        case (rd_sel)
            3'h0: a_read = address_register_set[0];
            3'h1: a_read = address_register_set[1];
            3'h2: a_read = address_register_set[2];
            3'h3: a_read = address_register_set[3];
            3'h4: a_read = address_register_set[4];
            3'h5: a_read = address_register_set[5];
            3'h6: a_read = address_register_set[6];
            default: a_read = active_sp;
        endcase
        case (idx_sel[2:0])
            3'h0: x_addr = address_register_set[0];
            3'h1: x_addr = address_register_set[1];
            3'h2: x_addr = address_register_set[2];
            3'h3: x_addr = address_register_set[3];
            3'h4: x_addr = address_register_set[4];
            3'h5: x_addr = address_register_set[5];
            3'h6: x_addr = address_register_set[6];
            default: x_addr = active_sp;
        endcase
        idx_raw = idx_sel[3] ? x_addr : data_register_set[idx_sel[2:0]]; // RQ5
        q_val = (quick_code == 3'h0) ? 4'h8 : {1'b0, quick_code}; // RQ10
    end
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            d_rdata <= 32'h00000000;
            a_rdata <= 32'h00000000;
            idx_value <= 32'h00000000;
            quick_value <= 32'h00000000;
            ea_valid <= 1'b0;
            type_valid <= 1'b0;
        end else begin
            d_rdata <= data_register_set[rd_sel];
            a_rdata <= a_read;
            idx_value <= idx_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]}; // RQ5
            quick_value <= {28'h0000000, q_val}; // RQ10
            ea_valid <= (ea_mode < `CPM_MODE_COUNT); // RQ9
            type_valid <= (ea_type <= `CPM_TYPE_LONG); // RQ9
        end
    end
endmodule

/* cpm_core_regs_bench.sv */
// Bench for the core register set
module cpm_core_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, resetn = 0, d_we, d_flags_en, d_flag_v, d_flag_c, d_flag_x, a_we, sr_we;
    logic sr_upper_we, ssp_we, pc_we, pc_inc, idx_long, ea_valid, type_valid, privilege_violation;
    logic [2:0] d_sel, a_sel, ea_type, quick_code, rd_sel;
    logic [1:0] d_size, a_size;
    logic [3:0] idx_sel, ea_mode;
    logic [15:0] sr_wdata, status_register;
    logic [31:0] d_wdata, a_wdata, ssp_wdata, pc_wdata, d_rdata, a_rdata, idx_value, quick_value;
    logic [31:0] program_counter, address_out, user_stack_pointer, supervisor_stack_pointer;
    logic [65:0] rows [3] = '{{2'h0, 32'h55, 32'haaaaaa55}, {2'h1, 32'h1234, 32'haaaa1234},
        {2'h2, 32'h87654321, 32'h87654321}};
    int err_total = 0, samples_checked = 0;
    cpm_core_regs uut (
        .clock(clock),
        .resetn(resetn),
        .d_we(d_we),
        .d_sel(d_sel),
        .d_size(d_size),
        .d_wdata(d_wdata),
        .d_flags_en(d_flags_en),
        .d_flag_v(d_flag_v),
        .d_flag_c(d_flag_c),
        .d_flag_x(d_flag_x),
        .a_we(a_we),
        .a_sel(a_sel),
        .a_size(a_size),
        .a_wdata(a_wdata),
        .sr_we(sr_we),
        .sr_upper_we(sr_upper_we),
        .sr_wdata(sr_wdata),
        .ssp_we(ssp_we),
        .ssp_wdata(ssp_wdata),
        .pc_we(pc_we),
        .pc_wdata(pc_wdata),
        .pc_inc(pc_inc),
        .idx_sel(idx_sel),
        .idx_long(idx_long),
        .ea_mode(ea_mode),
        .ea_type(ea_type),
        .quick_code(quick_code),
        .rd_sel(rd_sel),
        .d_rdata(d_rdata),
        .a_rdata(a_rdata),
        .idx_value(idx_value),
        .program_counter(program_counter),
        .address_out(address_out),
        .status_register(status_register),
        .user_stack_pointer(user_stack_pointer),
        .supervisor_stack_pointer(supervisor_stack_pointer),
        .quick_value(quick_value),
        .ea_valid(ea_valid),
        .type_valid(type_valid),
        .privilege_violation(privilege_violation)
    );
    always #20 clock = ~clock;
    task chk(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task go;
        @(negedge clock);
        {d_we, a_we, sr_we, sr_upper_we, ssp_we, pc_we, pc_inc} = '0;
        @(negedge clock);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {d_we, d_flags_en, d_flag_v, d_flag_c, d_flag_x, a_we, sr_we, sr_upper_we, ssp_we, pc_we,
            pc_inc, idx_long, d_sel, a_sel, ea_type, quick_code, rd_sel, d_size, a_size, idx_sel,
            ea_mode, sr_wdata, d_wdata, a_wdata, ssp_wdata, pc_wdata} = '0;
        repeat (16) @(negedge clock);
        chk("status", 32'(status_register), 32'h2700);
        resetn = 1;
        for (int i = 0; i < 3; i++) begin
            {d_we, d_sel, rd_sel, d_size, d_wdata} = {1'b1, 3'(i), 3'(i), 2'h2, 32'haaaaaaaa};
            go;
            {d_we, d_size, d_wdata} = {1'b1, rows[i][65:32]};
            go;
            chk("data", d_rdata, rows[i][31:0]);
        end
        {d_we, d_sel, d_size, d_wdata, d_flags_en, d_flag_v, d_flag_x} =
            {1'b1, 3'h3, 2'h0, 32'h80, 3'b111};
        go;
        chk("status", 32'(status_register), 32'h271a);
        {a_we, a_sel, rd_sel, a_size, a_wdata} = {1'b1, 3'h2, 3'h2, 2'h1, 32'h8000};
        go;
        chk("addr", a_rdata, 32'hffff8000);
        chk("status", 32'(status_register), 32'h271a);
        {idx_sel, idx_long} = {4'ha, 1'b1};
        go;
        chk("index", idx_value, 32'hffff8000);
        {idx_sel, idx_long} = {4'h3, 1'b0};
        go;
        chk("index", idx_value, 32'h80);
        {ssp_we, ssp_wdata} = {1'b1, 32'h1000};
        go;
        chk("ssp", supervisor_stack_pointer, 32'h1000);
        {sr_we, sr_upper_we, sr_wdata} = {2'b11, 16'h0000};
        go;
        {sr_we, sr_upper_we, sr_wdata} = {2'b11, 16'ha71f};
        @(negedge clock);
        chk("violation", 32'(privilege_violation), 32'h1);
        {sr_we, sr_upper_we} = '0;
        @(negedge clock);
        chk("status", 32'(status_register), 32'h001f);
        {ssp_we, ssp_wdata} = {1'b1, 32'h2000};
        go;
        chk("ssp", supervisor_stack_pointer, 32'h1000);
        {a_we, a_sel, rd_sel, a_size, a_wdata} = {1'b1, 3'h7, 3'h7, 2'h0, 32'hffff1234};
        go;
        chk("usp", user_stack_pointer, 32'h00001234);
        chk("addr", a_rdata, 32'h00001234);
        {pc_we, pc_wdata} = {1'b1, 32'h100};
        go;
        pc_inc = 1;
        @(negedge clock);
        go;
        chk("pc", program_counter, 32'h104);
        chk("address", address_out, 32'h104);
        for (int i = 0; i < 16; i++) begin
            {ea_mode, ea_type, quick_code} = {4'(i), 3'(i), 3'(i)};
            go;
            chk("ea", 32'(ea_valid), 32'(i < 14));
            chk("type", 32'(type_valid), 32'(i % 8 <= 4));
            chk("quick", quick_value, (i % 8 == 0) ? 32'h8 : 32'(i % 8));
        end
        resetn = 0;
        @(negedge clock);
        chk("status", 32'(status_register), 32'h2700);
        chk("pc", program_counter, 32'h0);
        chk("usp", user_stack_pointer, 32'h0);
        resetn = 1;
        go;
        test_done;
    end
    initial begin
        #100us;
        err_total++;
        test_done;
    end
endmodule
bind cpm_core_regs cpm_core_regs_props chk_i (
    .clock(clock),
    .resetn(resetn),
    .d_we(d_we),
    .d_flags_en(d_flags_en),
    .a_we(a_we),
    .sr_we(sr_we),
    .sr_upper_we(sr_upper_we),
    .ssp_we(ssp_we),
    .pc_we(pc_we),
    .pc_inc(pc_inc),
    .ea_valid(ea_valid),
    .privilege_violation(privilege_violation),
    .d_size(d_size),
    .a_size(a_size),
    .quick_code(quick_code),
    .ea_mode(ea_mode),
    .status_register(status_register),
    .d_wdata(d_wdata),
    .ssp_wdata(ssp_wdata),
    .program_counter(program_counter),
    .supervisor_stack_pointer(supervisor_stack_pointer),
    .quick_value(quick_value)
);

/* cpm_core_regs_props.sv */
// Port assertions for the core register set
module cpm_core_regs_props (
    input logic clock,
    input logic resetn,
    input logic d_we,
    input logic d_flags_en,
    input logic a_we,
    input logic sr_we,
    input logic sr_upper_we,
    input logic ssp_we,
    input logic pc_we,
    input logic pc_inc,
    input logic ea_valid,
    input logic privilege_violation,
    input logic [1:0] d_size,
    input logic [1:0] a_size,
    input logic [2:0] quick_code,
    input logic [3:0] ea_mode,
    input logic [15:0] status_register,
    input logic [31:0] d_wdata,
    input logic [31:0] ssp_wdata,
    input logic [31:0] program_counter,
    input logic [31:0] supervisor_stack_pointer,
    input logic [31:0] quick_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_sr_mask;
        (status_register & 16'h58e0) == 16'h0000;
    endproperty
    a_sr_mask: assert property (p_sr_mask) else $error("status reserved bit set");
    property p_upper_kept;
        sr_we && sr_upper_we && !status_register[13] |=>
            privilege_violation && status_register[15:8] == $past(status_register[15:8]);
    endproperty
    a_upper_kept: assert property (p_upper_kept) else $error("user upper write taken");
    property p_ssp_kept;
        ssp_we && !status_register[13] |=> $stable(supervisor_stack_pointer) && privilege_violation;
    endproperty
    a_ssp_kept: assert property (p_ssp_kept) else $error("user stack write taken");
    property p_ssp_load;
        ssp_we && status_register[13] |=> supervisor_stack_pointer == $past(ssp_wdata);
    endproperty
    a_ssp_load: assert property (p_ssp_load) else $error("stack load wrong");
    property p_quick;
        1 |=> quick_value == ($past(quick_code) == 3'h0 ? 32'h8 : {29'h0, $past(quick_code)});
    endproperty
    a_quick: assert property (p_quick) else $error("quick value wrong");
    property p_ea;
        1 |=> ea_valid == ($past(ea_mode) < 4'he);
    endproperty
    a_ea: assert property (p_ea) else $error("mode check wrong");
    property p_pc_inc;
        pc_inc && !pc_we |=> program_counter == $past(program_counter) + 32'h2;
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("counter step wrong");
    property p_addr_flags;
        a_we && !d_we && !sr_we |=> status_register[4:0] == $past(status_register[4:0]);
    endproperty
    a_addr_flags: assert property (p_addr_flags) else $error("flags moved");
    property p_neg;
        d_we && d_flags_en && !sr_we && d_size == 2'h0 |=> status_register[3] == $past(d_wdata[7]);
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    c_viol: cover property (privilege_violation);
    c_inc2: cover property (pc_inc ##1 pc_inc);
    c_aword: cover property (a_we && a_size == 2'h1);
endmodule

/* cpm_reg32.v */
// One 32-bit register with byte, word and long-word writes
module cpm_reg32 #(
    parameter WIDTH = 32
) (
    input wire clock,
    input wire resetn,
    input wire we,
    input wire [1:0] size,
    input wire [WIDTH-1:0] wdata,
    output reg [WIDTH-1:0] q
);
`include "cpm_consts.vh"
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= {WIDTH{1'b0}};
        end else if (we) begin
            case (size)
                `CPM_SIZE_BYTE: q[7:0] <= wdata[7:0];
                `CPM_SIZE_WORD: q[15:0] <= wdata[15:0];
                default: q <= wdata;
            endcase
        end
    end
endmodule
